// ==== bert_engine.sv ====
// top: pattern generator and error detector on a sampled bit clock
`timescale 1ns/1ps
module bert_engine (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic bit_clk,
    input wire logic rx_data,
    input wire logic aux_in,
    input wire logic err_inj_in,
    input wire logic gate_in,
    input wire logic sw_alt_req,
    input wire bert_pkg::gen_cfg_t gen_cfg,
    input wire bert_pkg::det_cfg_t det_cfg,
    input wire bert_pkg::mem_wr_t mem_wr,
    output logic tx_data,
    output logic pattern_b,
    output logic blanked,
    output logic trig_out,
    output logic err_out,
    output logic det_synced,
    output logic [47:0] bit_count,
    output logic [47:0] err_count
);
    typedef struct packed {
        logic bclk_s1;
        logic bclk_s2;
        logic bclk_s3;
        logic rx_s1;
        logic rx_s2;
        logic aux_s1;
        logic aux_s2;
        logic aux_s3;
        logic inj_s1;
        logic inj_s2;
        logic inj_s3;
        logic gate_s1;
        logic gate_s2;
        logic [3:0] aux_cnt;
        logic blank;
        logic inj_pend;
        logic alt_pend;
        logic pat_b;
        logic [24:0] gaddr;
        logic [4:0] gbit;
        logic [22:0] zpos;
        logic tx;
        logic [24:0] daddr;
        logic synced;
        logic [5:0] match_cnt;
        logic [8:0] dpos;
        logic seg_err;
        logic [6:0] seg_errs;
        logic err_out;
        logic gated;
        logic [47:0] bits;
        logic [47:0] errs;
        logic [1:0] rep_cnt;
        logic [6:0] div_cnt;
        logic trig;
    } engine_state_t;

    engine_state_t s_reg;
    engine_state_t n;

    logic [31:0] pat_mem [bert_pkg::MEM_WORDS];

    logic gtick;
    logic dtick;
    logic aux_rise;
    logic inj_rise;
    logic [24:0] g_eff;
    logic [24:0] g_end;
    logic g_mem_bit;
    logic d_mem_bit;
    logic g_prbs_bit;
    logic d_prbs_bit;
    logic [30:0] g_state;
    logic [30:0] g_mask;
    logic d_wrap;
    logic g_step;
    logic [22:0] z_last;
    logic z_hold;
    bert_pkg::src_t d_src;
    bert_pkg::prbs_t d_prbs;
    logic [24:0] d_len_m1;
    logic d_is_mem;
    logic rx_bit;
    logic exp_bit;
    logic bit_err;
    logic d_end;

    // edges of the sampled bit clock and strobes
    assign gtick = s_reg.bclk_s2 & ~s_reg.bclk_s3;
    assign dtick = det_cfg.fall_edge ? (~s_reg.bclk_s2 & s_reg.bclk_s3)
                                     : gtick;
    assign aux_rise = s_reg.aux_s2 & ~s_reg.aux_s3;
    assign inj_rise = s_reg.inj_s2 & ~s_reg.inj_s3;

    // generator memory address, pattern B in upper half
    assign g_eff = s_reg.pat_b ? (bert_pkg::ALT_B_BASE | s_reg.gaddr)
                               : s_reg.gaddr;
    assign g_end = gen_cfg.alt_en ? {1'b0, gen_cfg.len_m1[23:0]}
                                  : gen_cfg.len_m1;
    assign g_mem_bit = pat_mem[g_eff[24:5]][g_eff[4:0]];

    // zero-substitution frame is 2^n bits (2^23 for PRBS31): hold the PRBS once per frame
    assign g_mask = bert_pkg::prbs_mask(gen_cfg.prbs);
    assign z_last = g_mask[22:0];
    assign z_hold = (gen_cfg.src == bert_pkg::SRC_ZSUB)
                    && (s_reg.zpos == z_last);
    assign g_step = gtick && (gen_cfg.src != bert_pkg::SRC_MEM) && !z_hold;

    // detector pattern, shared with generator or its own
    assign d_src = det_cfg.follow_gen ? gen_cfg.src : det_cfg.src;
    assign d_prbs = det_cfg.follow_gen ? gen_cfg.prbs : det_cfg.prbs;
    assign d_len_m1 = det_cfg.follow_gen ? g_end : det_cfg.len_m1;
    assign d_is_mem = d_src == bert_pkg::SRC_MEM;
    assign d_mem_bit = pat_mem[s_reg.daddr[24:5]][s_reg.daddr[4:0]];
    assign rx_bit = s_reg.rx_s2 ^ det_cfg.invert;
    assign exp_bit = d_is_mem ? d_mem_bit : d_prbs_bit;
    assign bit_err = rx_bit != exp_bit;
    assign d_end = d_is_mem ? (s_reg.daddr == d_len_m1) : d_wrap;

    prbs_lfsr gen_prbs (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sel(gen_cfg.prbs),
        .step(g_step),
        .load(1'b0),
        .load_bit(1'b0),
        .out_bit(g_prbs_bit),
        .state(g_state),
        .wrap()
    );

    prbs_lfsr det_prbs (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sel(d_prbs),
        .step(dtick && !d_is_mem),
        .load(!s_reg.synced),
        .load_bit(rx_bit),
        .out_bit(d_prbs_bit),
        .state(),
        .wrap(d_wrap)
    );

    // pattern memory write port
    always_ff @(posedge ref_clk)
    begin
        if (mem_wr.en)
        begin
            pat_mem[mem_wr.addr] <= mem_wr.data;
        end
    end

    // next-state logic of generator and detector
    always_comb
    begin
        logic src_bit;
        logic out_bit;
        logic pend_clr;
        n = s_reg;
        src_bit = 1'b0;
        out_bit = 1'b0;
        pend_clr = 1'b0;
        // synchronisers
        n.bclk_s1 = bit_clk;
        n.bclk_s2 = s_reg.bclk_s1;
        n.bclk_s3 = s_reg.bclk_s2;
        n.rx_s1 = rx_data;
        n.rx_s2 = s_reg.rx_s1;
        n.aux_s1 = aux_in;
        n.aux_s2 = s_reg.aux_s1;
        n.aux_s3 = s_reg.aux_s2;
        n.inj_s1 = err_inj_in;
        n.inj_s2 = s_reg.inj_s1;
        n.inj_s3 = s_reg.inj_s2;
        n.gate_s1 = gate_in;
        n.gate_s2 = s_reg.gate_s1;

        // blanking request must stand its least time
        if (!s_reg.aux_s2)
        begin
            n.aux_cnt = 4'h0;
        end
        else if (s_reg.aux_cnt != 4'(bert_pkg::BLANK_MIN_CYC))
        begin
            n.aux_cnt = s_reg.aux_cnt + 4'h1;
        end

        // generator bit
        if (gtick)
        begin
            n.gbit = s_reg.gbit + 5'h01;
            unique case (gen_cfg.src)
                bert_pkg::SRC_MEM:
                begin
                    src_bit = g_mem_bit;
                end
                bert_pkg::SRC_PRBS:
                begin
                    src_bit = g_prbs_bit;
                end
                bert_pkg::SRC_ZSUB:
                begin
                    if (s_reg.zpos < gen_cfg.zsub_len
                        && s_reg.zpos < z_last)
                    begin
                        src_bit = 1'b0;
                    end
                    else if (s_reg.zpos == gen_cfg.zsub_len)
                    begin
                        src_bit = 1'b1;
                    end
                    else
                    begin
                        src_bit = g_prbs_bit;
                    end
                    n.zpos = z_hold ? 23'h000000
                                    : s_reg.zpos + 23'h000001;
                end
                bert_pkg::SRC_MARK:
                begin
                    unique case (gen_cfg.dens)
                        bert_pkg::MD_1_8:
                            src_bit = &g_state[2:0];
                        bert_pkg::MD_1_4:
                            src_bit = &g_state[1:0];
                        bert_pkg::MD_1_2:
                            src_bit = g_state[0];
                        bert_pkg::MD_3_4:
                            src_bit = |g_state[1:0];
                        bert_pkg::MD_7_8:
                            src_bit = |g_state[2:0];
                        default:
                            src_bit = g_state[0];
                    endcase
                end
            endcase
            out_bit = src_bit ^ s_reg.inj_pend;
            pend_clr = 1'b1;
            n.tx = out_bit & ~s_reg.blank;
            // blanking switches only at a 32-bit boundary
            if (s_reg.gbit == bert_pkg::BLANK_LAST)
            begin
                n.blank = !gen_cfg.alt_en
                          && s_reg.aux_cnt
                             == 4'(bert_pkg::BLANK_MIN_CYC);
            end
            // memory address and changeover at pattern end
            if (s_reg.gaddr >= g_end)
            begin
                n.gaddr = 25'h0000000;
                if (!gen_cfg.alt_en)
                begin
                    n.pat_b = 1'b0;
                end
                else if (gen_cfg.alt_level)
                begin
                    n.pat_b = s_reg.aux_s2 | gen_cfg.alt_sel;
                end
                else
                begin
                    n.pat_b = s_reg.alt_pend & ~s_reg.pat_b;
                    n.alt_pend = s_reg.alt_pend & s_reg.pat_b;
                end
            end
            else
            begin
                n.gaddr = s_reg.gaddr + 25'h0000001;
            end
        end

        // error inject: a new edge wins over the clear
        n.inj_pend = (s_reg.inj_pend & ~pend_clr) | inj_rise;
        // one-shot requests from aux edge or software
        if (gen_cfg.alt_en && !gen_cfg.alt_level
            && (aux_rise || sw_alt_req))
        begin
            n.alt_pend = 1'b1;
        end

        // detector
        if (dtick)
        begin
            if (!s_reg.synced)
            begin
                // hunt: memory restarts on a miss, prbs reloads
                if (bit_err)
                begin
                    n.match_cnt = 6'h00;
                    n.daddr = 25'h0000000;
                end
                else
                begin
                    n.match_cnt = s_reg.match_cnt + 6'h01;
                    n.daddr = d_end ? 25'h0000000
                                    : s_reg.daddr + 25'h0000001;
                    if (s_reg.match_cnt == bert_pkg::SYNC_MATCH - 6'h01)
                    begin
                        n.synced = 1'b1;
                        n.dpos = 9'h000;
                        n.seg_err = 1'b0;
                        n.seg_errs = 7'h00;
                    end
                end
            end
            else
            begin
                n.daddr = d_end ? 25'h0000000
                                : s_reg.daddr + 25'h0000001;
                n.dpos = s_reg.dpos + 9'h001;
                // counts while not gated
                if (!s_reg.gated)
                begin
                    n.bits = s_reg.bits + 48'h000000000001;
                    if (bit_err)
                    begin
                        n.errs = s_reg.errs + 48'h000000000001;
                    end
                end
                if (bit_err && s_reg.seg_errs != 7'h7F)
                begin
                    n.seg_errs = s_reg.seg_errs + 7'h01;
                end
                n.seg_err = s_reg.seg_err | bit_err;
                // 128-bit segment end: error pulse and sync check
                if (s_reg.dpos[6:0] == bert_pkg::SEG_LAST[6:0])
                begin
                    n.err_out = s_reg.seg_err | bit_err;
                    if (n.seg_errs >= bert_pkg::SYNC_LOSS)
                    begin
                        n.synced = 1'b0;
                        n.match_cnt = 6'h00;
                        n.err_out = 1'b0;
                    end
                    n.seg_err = 1'b0;
                    n.seg_errs = 7'h00;
                end
                // gate sampled once per 512-bit block
                if (s_reg.dpos == bert_pkg::GATE_LAST)
                begin
                    n.gated = s_reg.gate_s2;
                end
            end

            // trigger output
            if (det_cfg.trig_div)
            begin
                if (s_reg.div_cnt
                    >= bert_pkg::div_half(det_cfg.div) - 7'h01)
                begin
                    n.div_cnt = 7'h00;
                    n.trig = ~s_reg.trig;
                end
                else
                begin
                    n.div_cnt = s_reg.div_cnt + 7'h01;
                end
            end
            else
            begin
                n.trig = 1'b0;
                if (s_reg.synced && d_end)
                begin
                    n.rep_cnt = s_reg.rep_cnt + 2'h1;
                    n.trig = d_is_mem
                             || s_reg.rep_cnt
                                == bert_pkg::PRBS_TRIG_REP;
                end
            end
        end
        if (!s_reg.synced)
        begin
            n.err_out = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= n;
        end
    end

    // outputs straight from the state register
    assign tx_data = s_reg.tx;
    assign pattern_b = s_reg.pat_b;
    assign blanked = s_reg.blank;
    assign trig_out = s_reg.trig;
    assign err_out = s_reg.err_out;
    assign det_synced = s_reg.synced;
    assign bit_count = s_reg.bits;
    assign err_count = s_reg.errs;
endmodule

// ==== bert_pkg.sv ====
// package: constants and types of the bit error ratio pattern engine
// Operation
// - alternate mode splits pattern memory into halves for patterns A and B
// - one-shot mode: aux rising edge inserts one pattern B copy into A
// - level mode: aux high or alt_sel selects pattern B, otherwise pattern A
// - no alternate mode: aux high zeroes output from next 32-bit boundary
// - each error-inject rising edge corrupts exactly one output bit
// - patterns serve generator and detector, set jointly or separately
// - memory patterns may be one bit up to 33,554,432 bits long
// - alternate patterns are of equal length, each up to 16,777,216 bits
// - pattern changeover is only at pattern end; one-shot and alternate
// - hardware PRBS with taps 31 and 28, output inverted
// - inverted PRBS with taps 23/18, 15/14 and 11/9
// - inverted PRBS with taps 10/7 and 7/6
// - zero substitution extends zero run to the set length, then a one
// - mark density sets ones ratio to 1/8, 1/4, 1/2, 3/4 or 7/8
// - zero-substitution patterns are 2^n bits (2^23 for PRBS31), density patterns 2^n-1 bits, from base PRBS
// - detector compares every received bit; the input must be periodic
// - detector may invert received data and samples on chosen clock edge
// - pattern trigger tracks the pattern; PRBS pulses every 4th repetition
// - divided-clock trigger is a square wave at clock divided by 4 to 128
// - error output high 128 clocks when a 128-bit segment held an error
// - gating input high excludes bits, in whole 512-bit blocks
package bert_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int BLANK_MIN_NS = 100;
    localparam int BLANK_MIN_CYC =
        (BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MEM_WORDS = 1048576;
    localparam logic [24:0] ALT_B_BASE = 25'h1000000;
    localparam logic [8:0] SEG_LAST = 9'h07F;
    localparam logic [8:0] GATE_LAST = 9'h1FF;
    localparam logic [4:0] BLANK_LAST = 5'h1F;
    localparam logic [5:0] SYNC_MATCH = 6'h20;
    localparam logic [6:0] SYNC_LOSS = 7'h20;
    localparam logic [1:0] PRBS_TRIG_REP = 2'h3;
    localparam logic [30:0] LFSR_SEED = 31'h7FFFFFFF;

    typedef enum logic [1:0] {SRC_MEM, SRC_PRBS, SRC_ZSUB, SRC_MARK} src_t;
    typedef enum logic [2:0] {
        PRBS31, PRBS23, PRBS15, PRBS13, PRBS11, PRBS10, PRBS7
    } prbs_t;
    typedef enum logic [2:0] {MD_1_8, MD_1_4, MD_1_2, MD_3_4, MD_7_8} dens_t;
    typedef enum logic [2:0] {
        DIV4, DIV8, DIV16, DIV32, DIV40, DIV64, DIV128
    } div_t;

    typedef struct packed {
        src_t src;
        prbs_t prbs;
        dens_t dens;
        logic [22:0] zsub_len;
        logic [24:0] len_m1;
        logic alt_en;
        logic alt_level;
        logic alt_sel;
    } gen_cfg_t;

    typedef struct packed {
        logic follow_gen;
        src_t src;
        prbs_t prbs;
        logic [24:0] len_m1;
        logic invert;
        logic fall_edge;
        logic trig_div;
        div_t div;
    } det_cfg_t;

    typedef struct packed {
        logic en;
        logic [19:0] addr;
        logic [31:0] data;
    } mem_wr_t;

    // feedback taps, bit k is stage k+1
    function automatic logic [30:0] prbs_taps(prbs_t s);
        unique case (s)
            PRBS31: prbs_taps = 31'h48000000;
            PRBS23: prbs_taps = 31'h00420000;
            PRBS15: prbs_taps = 31'h00006000;
            PRBS13: prbs_taps = 31'h00001C80;
            PRBS11: prbs_taps = 31'h00000500;
            PRBS10: prbs_taps = 31'h00000240;
            PRBS7: prbs_taps = 31'h00000060;
            default: prbs_taps = 31'h00000060;
        endcase
    endfunction

    // mask of the register stages in use
    function automatic logic [30:0] prbs_mask(prbs_t s);
        unique case (s)
            PRBS31: prbs_mask = 31'h7FFFFFFF;
            PRBS23: prbs_mask = 31'h007FFFFF;
            PRBS15: prbs_mask = 31'h00007FFF;
            PRBS13: prbs_mask = 31'h00001FFF;
            PRBS11: prbs_mask = 31'h000007FF;
            PRBS10: prbs_mask = 31'h000003FF;
            PRBS7: prbs_mask = 31'h0000007F;
            default: prbs_mask = 31'h0000007F;
        endcase
    endfunction

    // half period of the divided trigger, in bits
    function automatic logic [6:0] div_half(div_t d);
        unique case (d)
            DIV4: div_half = 7'h02;
            DIV8: div_half = 7'h04;
            DIV16: div_half = 7'h08;
            DIV32: div_half = 7'h10;
            DIV40: div_half = 7'h14;
            DIV64: div_half = 7'h20;
            DIV128: div_half = 7'h40;
            default: div_half = 7'h40;
        endcase
    endfunction
endpackage

// ==== prbs_lfsr.sv ====
// prbs shift register with inverted output and self-sync loading
`timescale 1ns/1ps
module prbs_lfsr (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire bert_pkg::prbs_t sel,
    input wire logic step,
    input wire logic load,
    input wire logic load_bit,
    output logic out_bit,
    output logic [30:0] state,
    output logic wrap
);
    typedef struct packed {
        logic [30:0] sr;
    } lfsr_state_t;

    lfsr_state_t s_reg;
    lfsr_state_t s_next;
    logic [30:0] mask;
    logic fb;

    // feedback and inverted output
    assign mask = bert_pkg::prbs_mask(sel);
    assign fb = ^(s_reg.sr & bert_pkg::prbs_taps(sel));
    assign out_bit = ~fb;
    assign state = s_reg.sr;
    assign wrap = (s_reg.sr & mask) == mask;

    // shift, or take received bit while hunting
    always_comb
    begin
        s_next = s_reg;
        if (step)
        begin
            s_next.sr = {s_reg.sr[29:0], load ? ~load_bit : fb} & mask;
            if (s_next.sr == 31'h00000000)
            begin
                s_next.sr = mask; // escape the locked all-zero state
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_reg.sr <= bert_pkg::LFSR_SEED;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
endmodule

// ==== bert_engine_chk.sv ====
// checker: port-level properties of the pattern engine
`timescale 1ns/1ps
module bert_engine_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic bit_clk,
    input wire bert_pkg::gen_cfg_t gen_cfg,
    input wire logic tx_data,
    input wire logic pattern_b,
    input wire logic blanked,
    input wire logic err_out,
    input wire logic det_synced,
    input wire logic [47:0] bit_count,
    input wire logic [47:0] err_count
);
    logic bclk_reg;
    logic [9:0] ecnt_reg;
    logic [7:0] since_reg;
    // bit edges while err_out is high, and since the last counted error
    always_ff @(posedge ref_clk)
    begin
        bclk_reg <= bit_clk;
        if (!rst_n || !err_out)
            ecnt_reg <= 10'h000;
        else if (bit_clk && !bclk_reg)
            ecnt_reg <= ecnt_reg + 10'h001;
        if (!rst_n || err_count != $past(err_count))
            since_reg <= 8'h00;
        else if (bit_clk && !bclk_reg && since_reg != 8'hFF)
            since_reg <= since_reg + 8'h01;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_err_width;
        $fell(err_out) |-> ecnt_reg >= 10'h07F &&
            (ecnt_reg[6:0] <= 7'h01 || ecnt_reg[6:0] == 7'h7F);
    endproperty
    a_err_width: assert property (p_err_width)
        else $error("error pulse not 128 bits wide");
    property p_err_cause;
        $rose(err_out) |-> since_reg <= 8'h82 ||
            err_count != $past(err_count);
    endproperty
    a_err_cause: assert property (p_err_cause)
        else $error("error pulse without an error in the segment");
    // tx settles within 16 cycles of the blanking boundary at this bit rate
    property p_blank_zero;
        blanked && $past(blanked, 16) |-> !tx_data;
    endproperty
    a_blank_zero: assert property (p_blank_zero)
        else $error("data not zero while blanked");
    property p_blank_alt;
        gen_cfg.alt_en |-> !blanked;
    endproperty
    a_blank_alt: assert property (p_blank_alt)
        else $error("blanking in alternate mode");
    property p_no_b;
        !gen_cfg.alt_en |-> !pattern_b;
    endproperty
    a_no_b: assert property (p_no_b)
        else $error("pattern b without alternate mode");
    property p_err_le;
        err_count <= bit_count;
    endproperty
    a_err_le: assert property (p_err_le)
        else $error("more errors than compared bits");
    property p_bit_step;
        $past(rst_n) |-> bit_count - $past(bit_count) <= 48'h000000000001;
    endproperty
    a_bit_step: assert property (p_bit_step)
        else $error("bit count jumped");
    property p_unsync_frozen;
        !det_synced && $past(!det_synced) |->
            $stable(bit_count) && $stable(err_count);
    endproperty
    a_unsync_frozen: assert property (p_unsync_frozen)
        else $error("counting while not aligned");
    c_sync: cover property ($rose(det_synced));
    c_blank: cover property ($rose(blanked));
    c_err: cover property ($rose(err_out));
endmodule
bind bert_engine bert_engine_chk chk (.ref_clk, .rst_n, .bit_clk, .gen_cfg,
    .tx_data, .pattern_b, .blanked, .err_out, .det_synced, .bit_count,
    .err_count);

// ==== serial_dut_model.sv ====
// serial device under test: loops generator bits back to the detector
`timescale 1ns/1ps
module serial_dut_model (
    input wire logic tx_data,
    output logic bit_clk,
    output logic rx_data
);
    // free-running 320 ns bit clock, offset from the system clock
    initial
    begin
        bit_clk = 1'b0;
        rx_data = 1'b0;
        #7;
        forever #160 bit_clk = ~bit_clk;
    end
    // returned bit launched mid-bit, on the falling edge
    always @(negedge bit_clk)
        rx_data <= tx_data;
endmodule

// ==== bert_engine_tb_top.sv ====
// self-checking bench of the pattern engine in loopback
`timescale 1ns/1ps
module bert_engine_tb_top;
    logic ref_clk;
    logic rst_n;
    logic bit_clk;
    logic rx_data;
    logic aux_in;
    logic err_inj_in;
    logic gate_in;
    bert_pkg::gen_cfg_t gen_cfg;
    bert_pkg::det_cfg_t det_cfg;
    logic tx_data;
    logic pattern_b;
    logic blanked;
    logic trig_out;
    logic err_out;
    logic det_synced;
    logic [47:0] bit_count;
    logic [47:0] err_count;
    int miscompares;
    int checks_done;
    int cycles;

    bert_engine dut (.ref_clk(ref_clk), .rst_n(rst_n), .bit_clk(bit_clk),
        .rx_data(rx_data), .aux_in(aux_in), .err_inj_in(err_inj_in),
        .gate_in(gate_in), .sw_alt_req(1'b0), .gen_cfg(gen_cfg),
        .det_cfg(det_cfg), .mem_wr('0), .tx_data(tx_data),
        .pattern_b(pattern_b), .blanked(blanked), .trig_out(trig_out),
        .err_out(err_out), .det_synced(det_synced),
        .bit_count(bit_count), .err_count(err_count));
    serial_dut_model link (.tx_data(tx_data), .bit_clk(bit_clk),
        .rx_data(rx_data));

    task automatic close_out();
        if (miscompares == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // compare one flag
    task automatic chk_bit(string name, logic exp, logic got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s exp %b got %b", name, exp, got);
        end
    endtask
    // compare one counter
    task automatic chk_cnt(string name, logic [47:0] exp, logic [47:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s exp %0d got %0d", name, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // loopback locks, then counts 100 bits in 800 cycles with no error
    task automatic t_sync();
        logic [47:0] b0;
        for (int i = 0; i < 4000 && det_synced !== 1'b1; i++)
            tick(1);
        chk_bit("det_synced", 1'b1, det_synced);
        b0 = bit_count;
        tick(800);
        b0 = bit_count - b0;
        chk_bit("bits_100", 1'b1, b0 >= 48'h63 && b0 <= 48'h65);
        chk_cnt("err_count", 48'h0, err_count);
    endtask
    // pattern trigger: one pulse per four prbs7 repetitions
    task automatic t_trig();
        int gap;
        for (int i = 0; i < 4100 && trig_out !== 1'b1; i++)
            tick(1);
        tick(8);
        for (gap = 8; gap < 4100 && trig_out !== 1'b1; gap++)
            tick(1);
        chk_cnt("trig_gap", 48'h0FE0, 48'(gap));
    endtask
    // inverted x7+x6 sequence obeys an xnor recurrence
    task automatic t_prbs();
        logic [126:0] c;
        for (int i = 0; i < 127; i++)
        begin
            @(negedge bit_clk);
            c[i] = tx_data;
        end
        for (int n = 7; n < 127; n++)
            chk_bit("prbs7", ~(c[n-6] ^ c[n-7]), c[n]);
    endtask
    // one inject edge gives one counted error and one error pulse
    task automatic t_inject();
        logic [47:0] e0;
        logic seen;
        e0 = err_count;
        seen = 1'b0;
        tick(1);
        err_inj_in = 1'b1;
        tick(4);
        err_inj_in = 1'b0;
        for (int i = 0; i < 2400; i++)
        begin
            tick(1);
            seen |= err_out;
        end
        chk_cnt("err_count", e0 + 48'h1, err_count);
        chk_bit("err_seen", 1'b1, seen);
        chk_bit("err_after", 1'b0, err_out);
    endtask
    // gated span freezes the count for whole 512-bit blocks
    task automatic t_gate();
        logic [47:0] b0;
        int run;
        int best;
        run = 0;
        best = 0;
        tick(1);
        gate_in = 1'b1;
        b0 = bit_count;
        for (int i = 0; i < 9600; i++)
        begin
            tick(1);
            if (i == 4800)
                gate_in = 1'b0;
            run = (bit_count === b0) ? run + 1 : 0;
            best = (run > best) ? run : best;
            b0 = bit_count;
        end
        chk_bit("gate_len", 1'b1,
            best > 4000 && (best + 16) % 4096 < 32);
        tick(100);
        chk_bit("count_again", 1'b1, bit_count !== b0);
    endtask
    // 80 ns request is ignored, a held one blanks at a boundary
    task automatic t_blank();
        logic seen;
        seen = 1'b0;
        tick(1);
        aux_in = 1'b1;
        tick(2);
        aux_in = 1'b0;
        for (int i = 0; i < 400; i++)
        begin
            tick(1);
            seen |= blanked;
        end
        chk_bit("short_req", 1'b0, seen);
        aux_in = 1'b1;
        tick(600);
        chk_bit("blanked", 1'b1, blanked);
        chk_bit("pattern_b", 1'b0, pattern_b);
        seen = 1'b0;
        for (int i = 0; i < 100; i++)
        begin
            tick(1);
            seen |= tx_data;
        end
        chk_bit("tx_zero", 1'b0, seen);
        aux_in = 1'b0;
        tick(600);
        chk_bit("released", 1'b0, blanked);
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // cycle ceiling against hangs
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            close_out();
        end
    end
    // prbs7 on both sides, detector following the generator
    initial
    begin
        rst_n = 1'b0;
        aux_in = 1'b0;
        err_inj_in = 1'b0;
        gate_in = 1'b0;
        gen_cfg = '0;
        gen_cfg.src = bert_pkg::SRC_PRBS;
        gen_cfg.prbs = bert_pkg::PRBS7;
        det_cfg = '0;
        det_cfg.follow_gen = 1'b1;
        det_cfg.src = bert_pkg::SRC_PRBS;
        det_cfg.prbs = bert_pkg::PRBS7;
        tick(6);
        chk_cnt("bit_count_rst", 48'h0, bit_count);
        rst_n = 1'b1;
        t_sync();
        t_trig();
        t_prbs();
        t_inject();
        t_gate();
        t_blank();
        close_out();
    end
endmodule
